// >>> logic/asc_host.sv
// Host controller that drives an asynchronous 16-bit static memory through its pins.
// Summary of operation
// - A write starts only when all qualifiers are active and ends at the first that drops.
// - Write data setup and hold are timed to the edge that ends the write.
// - The host must not drive data while the memory drives it.
// - The write strobe stays high through every read cycle.
// - Address is valid no later than the selects are asserted on a read.
// - Selects and lane selects are always driven to a definite level.
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"
module asc_host #(
   parameter int ADDR_W = 21,
   parameter int CNT_W  = `ASC_CNT_W
)(
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   // User request side.
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [15:0]       req_wdata_in,
   input  wire logic [1:0]        req_lanes_in,
   output logic                   req_ready_out,
   output logic                   rd_valid_out,
   output logic [15:0]            rd_data_out,
   // Memory pins.
   output logic [ADDR_W-1:0]      mem_addr_out,
   output logic                   mem_sel_n_out,
   output logic                   mem_sel_out,
   output logic                   mem_we_n_out,
   output logic                   mem_oe_n_out,
   output logic                   upper_lane_sel_n_out,
   output logic                   lower_lane_sel_n_out,
   input  wire logic [15:0]       mem_dq_in,
   output logic [15:0]            mem_dq_out,
   output logic [1:0]             mem_dq_oe_out
);
   // Refuse widths that the address pins or the interval timer cannot serve.
   if (ADDR_W < 1 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("ADDR_W out of range");
   end
   if ((1 << CNT_W) <= `ASC_RD_CYC)
   begin : g_bad_cnt_w
      $error("CNT_W too small for the longest interval");
   end

   // ************************************************************
   // Interval counts and access sequencer
   // ************************************************************
   localparam logic [CNT_W-1:0] RD_CNT   = CNT_W'(`ASC_RD_CYC);
   localparam logic [CNT_W-1:0] WR_CNT   = CNT_W'(`ASC_WR_CYC);
   localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(`ASC_TURN_CYC);

   asc_pkg::asc_state_type state_r, state_nxt;
   logic              wr_r;
   logic [1:0]        lanes_r;
   logic [ADDR_W-1:0] addr_r;
   logic [15:0]       wdata_r;
   logic [15:0]       rdata_r;
   logic              rvalid_r;
   logic              tmr_load;
   logic [CNT_W-1:0]  tmr_count;
   logic              tmr_done;

   wire take_req  = (state_r == asc_pkg::ASC_IDLE) && req_valid_in && (req_lanes_in != 2'h0);
   wire in_pulse  = (state_r == asc_pkg::ASC_PULSE);
   wire in_access = (state_r == asc_pkg::ASC_SETUP) || in_pulse || (state_r == asc_pkg::ASC_END);

   asc_wait_timer #(.CNT_W(CNT_W)) u_timer (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .load_in  (tmr_load),
      .count_in (tmr_count),
      .done_out (tmr_done)
   );

   // Sequence: setup presents address, pulse holds the strobe, end releases it.
   always_comb
   begin
      state_nxt = state_r;
      tmr_load  = 1'b0;
      tmr_count = '0;
      case (state_r)
         asc_pkg::ASC_IDLE:
            if (take_req)
               state_nxt = asc_pkg::ASC_SETUP;
         asc_pkg::ASC_SETUP:
         begin
            state_nxt = asc_pkg::ASC_PULSE;
            tmr_load  = 1'b1;
            tmr_count = wr_r ? WR_CNT : RD_CNT;
         end
         asc_pkg::ASC_PULSE:
            if (tmr_done)
               state_nxt = asc_pkg::ASC_END;
         asc_pkg::ASC_END:
         begin
            state_nxt = asc_pkg::ASC_TURN;
            tmr_load  = 1'b1;
            tmr_count = TURN_CNT;
         end
         asc_pkg::ASC_TURN:
            if (tmr_done)
               state_nxt = asc_pkg::ASC_IDLE;
         default:
            state_nxt = asc_pkg::ASC_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state_r <= asc_pkg::ASC_IDLE;
      else
         state_r <= state_nxt;
   end

   // Request capture; address is held stable through the whole access.
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_r    <= 1'b0;
         lanes_r <= 2'h0;
         addr_r  <= '0;
         wdata_r <= 16'h0000;
      end
      else if (take_req)
      begin
         wr_r    <= req_write_in;
         lanes_r <= req_lanes_in;
         addr_r  <= req_addr_in;
         wdata_r <= req_wdata_in;
      end
   end

   // Read data is sampled on the last pulse cycle, after the access time has passed.
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= in_pulse && tmr_done && !wr_r;
         if (in_pulse && tmr_done && !wr_r)
            rdata_r <= {lanes_r[1] ? mem_dq_in[15:8] : 8'h00,
                        lanes_r[0] ? mem_dq_in[7:0] : 8'h00};
      end
   end

   // ************************************************************
   // Memory pin drive
   // ************************************************************
   // address valid no later than selects
   assign mem_addr_out  = addr_r;
   assign mem_sel_n_out = !in_access;
   assign mem_sel_out   = in_access;
   assign upper_lane_sel_n_out = !(in_access && lanes_r[1]);
   assign lower_lane_sel_n_out = !(in_access && lanes_r[0]);
   assign mem_we_n_out = !(in_pulse && wr_r);
   assign mem_oe_n_out = !(in_access && !wr_r);
   assign mem_dq_out    = wdata_r;
   assign mem_dq_oe_out = (in_access && wr_r) ? lanes_r : 2'h0;

   assign req_ready_out = (state_r == asc_pkg::ASC_IDLE);
   assign rd_valid_out  = rvalid_r;
   assign rd_data_out   = rdata_r;

   // ************************************************************
   // Protocol checks
   // ************************************************************
   // strobe high on reads
   a_read_no_strobe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (!wr_r && in_access) |-> mem_we_n_out)
      else $error("write strobe low during read");
   a_no_drive_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      !mem_oe_n_out |-> (mem_dq_oe_out == 2'h0))
      else $error("host drives data while memory gate open");
   a_strobe_inside: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      !mem_we_n_out |-> (!mem_sel_n_out && mem_sel_out &&
      !(upper_lane_sel_n_out && lower_lane_sel_n_out)))
      else $error("strobe without qualifiers");
   a_data_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      $rose(mem_we_n_out) |-> ($stable(mem_dq_out) && (mem_dq_oe_out != 2'h0)))
      else $error("write data not held at write end");
   // strobe held long
   // The strobe must cover the minimum pulse width in whole clock cycles.
   sequence s_strobe_held;
      !mem_we_n_out [*3];
   endsequence
   a_pulse_width: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      $fell(mem_we_n_out) |-> s_strobe_held)
      else $error("write pulse too short");
   a_addr_stable: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (in_access && $past(in_access)) |-> $stable(mem_addr_out))
      else $error("address moved during access");
   a_sel_pair: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      mem_sel_out == !mem_sel_n_out)
      else $error("select pins disagree");
   a_lanes_sel: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      mem_sel_n_out |-> (upper_lane_sel_n_out && lower_lane_sel_n_out))
      else $error("lane select outside access");
endmodule
`default_nettype wire

// >>> logic/asc_pkg.sv
// Types for the asynchronous static memory host controller.
`default_nettype none
package asc_pkg;
   typedef enum logic [2:0]
   {
      ASC_IDLE  = 3'h0,
      ASC_SETUP = 3'h1,
      ASC_PULSE = 3'h3,
      ASC_END   = 3'h2,
      ASC_TURN  = 3'h6
   } asc_state_type;
endpackage
`default_nettype wire

// >>> logic/asc_regs.svh
// Timing constants for the asynchronous static memory host controller.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CLK_PERIOD_NS 20
`define ASC_T_RC_NS   55
`define ASC_T_AA_NS   55
`define ASC_T_WC_NS   55
`define ASC_T_PWE_NS  40
`define ASC_T_SD_NS   25
`define ASC_T_HZWE_NS 20
`define ASC_CYC_CEIL(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_RD_CYC  `ASC_CYC_CEIL(`ASC_T_AA_NS)
`define ASC_WR_CYC  `ASC_CYC_CEIL(`ASC_T_PWE_NS)
`define ASC_TURN_CYC `ASC_CYC_CEIL(`ASC_T_HZWE_NS)
`define ASC_CNT_W 4
`endif

// >>> logic/asc_wait_timer.sv
// Down counter that times each asynchronous interval in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module asc_wait_timer #(
   parameter int CNT_W = 4
)(
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             load_in,
   input  wire logic [CNT_W-1:0] count_in,
   output logic                  done_out
);
   logic [CNT_W-1:0] cnt_r;

   // A zero-width counter could not time any interval, so refuse it at elaboration.
   if (CNT_W < 1)
   begin : g_bad_cnt_w
      $error("CNT_W must be at least 1");
   end

   // Load wins over counting so a new interval always starts cleanly.
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt_r <= '0;
      else if (load_in)
         cnt_r <= count_in;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   assign done_out = (cnt_r == '0) && !load_in;
endmodule
`default_nettype wire

// >>> verification/asc_sram_model.sv
// Behavioural model of the asynchronous 16-bit static memory behind the host controller.
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
   input  wire logic [20:0] addr_in,
   input  wire logic        sel_n_in,
   input  wire logic        sel_in,
   input  wire logic        we_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        upper_lane_sel_n_in,
   input  wire logic        lower_lane_sel_n_in,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic [1:0]       dq_en_out
);
   // ************************************************************
   // Mode decode and storage
   // ************************************************************
   logic [15:0] mem_r [0:255];
   logic        chip_on;
   logic        wr_on;
   logic        rd_on;
   assign chip_on = !sel_n_in && sel_in && !(upper_lane_sel_n_in && lower_lane_sel_n_in);
   assign wr_on = chip_on && !we_n_in;
   assign rd_on = chip_on && we_n_in && !oe_n_in;
   assign dq_en_out = rd_on ? ~{upper_lane_sel_n_in, lower_lane_sel_n_in} : 2'h0;
   assign dq_out = mem_r[addr_in[7:0]];
   // Only the low address bits are kept, so high addresses alias; the bench mirrors that.
   initial
   begin
      for (int i = 0; i < 256; i++) mem_r[i] = 16'h0;
   end
   // lane capture while overlapped; the last value before the end edge stays.
   always @*
   begin
      if (wr_on && !lower_lane_sel_n_in) mem_r[addr_in[7:0]][7:0] = dq_in[7:0];
      if (wr_on && !upper_lane_sel_n_in) mem_r[addr_in[7:0]][15:8] = dq_in[15:8];
   end
endmodule
`default_nettype wire

// >>> verification/async_sram_byte_lane_access_bench.sv
// Self-checking bench for the asynchronous static memory host controller.
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_access_bench;
   // ************************************************************
   // Signals, instances and the shared data wire
   // ************************************************************
   logic        clock_in, rst_n_in, req_valid_in, req_write_in, req_ready_out, rd_valid_out;
   logic [20:0] req_addr_in, mem_addr_out;
   logic [15:0] req_wdata_in, rd_data_out, mem_dq_out, ram_dq, dq_w, shadow [0:255];
   logic [1:0]  req_lanes_in, mem_dq_oe_out, ram_en;
   logic        sel_n, sel, we_n, oe_n, up_n, lo_n;
   logic [7:0]  flt_r;
   int          n_fail, cmp_count;
   logic [15:0] pins_w;
   asc_host i_asc_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
      .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .req_lanes_in(req_lanes_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out), .mem_addr_out(mem_addr_out), .mem_sel_n_out(sel_n),
      .mem_sel_out(sel), .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
      .upper_lane_sel_n_out(up_n), .lower_lane_sel_n_out(lo_n), .mem_dq_in(dq_w),
      .mem_dq_out(mem_dq_out), .mem_dq_oe_out(mem_dq_oe_out));
   asc_sram_model i_asc_sram_model (.addr_in(mem_addr_out), .sel_n_in(sel_n), .sel_in(sel),
      .we_n_in(we_n), .oe_n_in(oe_n), .upper_lane_sel_n_in(up_n), .lower_lane_sel_n_in(lo_n),
      .dq_in(dq_w), .dq_out(ram_dq), .dq_en_out(ram_en));
   // An undriven lane shows a pattern that moves every cycle out of reset (8'h5a low, 8'ha5 high in reset), so stale data never passes.
   assign dq_w[7:0] = mem_dq_oe_out[0] ? mem_dq_out[7:0] : ram_en[0] ? ram_dq[7:0] : flt_r;
   assign dq_w[15:8] = mem_dq_oe_out[1] ? mem_dq_out[15:8] : ram_en[1] ? ram_dq[15:8] : ~flt_r;
   always @(posedge clock_in) flt_r <= rst_n_in ? flt_r + 8'h3b : 8'h5a;
   // Pin levels packed for the reset check, ready first and lane drive enables last.
   assign pins_w = {6'h0, req_ready_out, rd_valid_out, sel_n, sel, we_n, oe_n,
                    up_n, lo_n, mem_dq_oe_out};
   initial
   begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // ************************************************************
   // Checking helpers and the bus access task
   // ************************************************************
   function automatic logic [15:0] exp_rd(input logic [15:0] w, input logic [1:0] ln);
      return w & {{8{ln[1]}}, {8{ln[0]}}};
   endfunction
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
      cmp_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bump(inout int k);
      k++;
      if (k > 40)
      begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d,
                         input logic [1:0] ln);
      int          k;
      logic        seen;
      logic [15:0] got;
      k = 0;
      seen = 1'b0;
      got = 16'h0;
      @(negedge clock_in);
      while (req_ready_out !== 1'b1)
      begin
         bump(k);
         @(negedge clock_in);
      end
      @(posedge clock_in);
      req_valid_in <= 1'b1;
      req_write_in <= wr;
      req_addr_in <= a;
      req_wdata_in <= d;
      req_lanes_in <= ln;
      @(posedge clock_in);
      req_valid_in <= 1'b0;
      if (wr && ln[0]) shadow[a[7:0]][7:0] = d[7:0];
      if (wr && ln[1]) shadow[a[7:0]][15:8] = d[15:8];
      repeat (12)
      begin
         @(negedge clock_in);
         if (rd_valid_out === 1'b1) got = rd_data_out;
         if (rd_valid_out === 1'b1) seen = 1'b1;
      end
      check("rd_valid", {15'h0, !wr && ln != 2'h0}, {15'h0, seen});
      if (seen) check("rd_data", exp_rd(shadow[a[7:0]], ln), got);
   endtask
   // Host and memory never drive one lane together.
   always @(negedge clock_in)
      if (rst_n_in) check("contention", 16'h0, {14'h0, mem_dq_oe_out & ram_en});
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      rst_n_in = 1'b0;
      req_valid_in = 1'b0;
      req_write_in = 1'b0;
      req_addr_in = 21'h0;
      req_wdata_in = 16'h0;
      req_lanes_in = 2'h0;
      n_fail = 0;
      cmp_count = 0;
      for (int i = 0; i < 256; i++) shadow[i] = 16'h0;
      void'($urandom(14227));
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'b1;
      access(1'b1, 21'h0, 16'ha55a, 2'h3);
      access(1'b1, 21'h0, 16'hffff, 2'h1);
      access(1'b0, 21'h0, 16'h0, 2'h2);
      access(1'b0, 21'h0, 16'h0, 2'h1);
      access(1'b0, 21'h0, 16'h0, 2'h0);
      access(1'b1, 21'h1fffff, 16'h1234, 2'h2);
      access(1'b0, 21'h1fffff, 16'h0, 2'h3);
      // A reset in the middle of a read must abort it and park every pin at once.
      @(posedge clock_in);
      req_valid_in <= 1'b1;
      req_write_in <= 1'b0;
      req_lanes_in <= 2'h3;
      @(posedge clock_in);
      req_valid_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      rst_n_in <= 1'b0;
      @(negedge clock_in);
      check("reset_pins", 16'h02bc, pins_w);
      check("reset_rdata", 16'h0000, rd_data_out);
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (80)
         access(1'($urandom % 2), 21'($urandom % 8), 16'($urandom), 2'($urandom % 4));
      tally_and_finish();
   end
endmodule
`default_nettype wire
